// ===== dicd_pkg.sv
package dicd_pkg;
    // terminal count and function code width
    localparam int NUM_TERM = 5;
    localparam int FUNC_W   = 6;
    // function codes
    localparam logic [5:0] FN_NONE    = 6'h00;
    localparam logic [5:0] FN_RESET   = 6'h01;
    localparam logic [5:0] FN_COAST   = 6'h02;
    localparam logic [5:0] FN_CLR_CST = 6'h03;
    localparam logic [5:0] FN_QSTOP   = 6'h04;
    localparam logic [5:0] FN_DCHOLD  = 6'h05;
    localparam logic [5:0] FN_STOP    = 6'h06;
    localparam logic [5:0] FN_START   = 6'h07;
    localparam logic [5:0] FN_LATCH   = 6'h08;
    localparam logic [5:0] FN_REV     = 6'h09;
    localparam logic [5:0] FN_STREV   = 6'h0a;
    localparam logic [5:0] FN_FWD_EN  = 6'h0b;
    localparam logic [5:0] FN_REV_EN  = 6'h0c;
    localparam logic [5:0] FN_INCH    = 6'h0d;
    localparam logic [5:0] FN_FRZ_REF = 6'h0e;
    localparam logic [5:0] FN_FRZ_OUT = 6'h0f;
    localparam logic [5:0] FN_SPD_UP  = 6'h10;
    localparam logic [5:0] FN_SPD_DN  = 6'h11;
    localparam logic [5:0] FN_RAMP2   = 6'h15;
    localparam logic [5:0] FN_PRE_LSB = 6'h16;
    localparam logic [5:0] FN_PRE_MSB = 6'h17;
    localparam logic [5:0] FN_PRE_ON  = 6'h18;
    // default function per terminal (18,19,27,29,33)
    localparam logic [29:0] FUNC_RST = {6'h00, 6'h0d, 6'h03, 6'h09, 6'h07};
    // bypass limits in Hz (tenths for skip)
    localparam int BW_MAX_HZ    = 100;
    localparam int SKIP_MAX_D10 = 10000;
    localparam logic [13:0] SKIP_RST = 14'h0000;
    // pulse timing
    localparam int PULSE_MS = 14;
    localparam int CLK_KHZ  = 125000;
    localparam int PULSE_CYC = PULSE_MS * CLK_KHZ;
    localparam int CNT_W = 21;
    localparam logic [15:0] HOLD_STEP = 16'h0001; // 0.1 % or 0.1 Hz
    localparam logic [15:0] HOLD_RST  = 16'h0000;
    // stop type encoding
    typedef enum logic [4:0] {
        DICD_STP_NONE  = 5'h01,
        DICD_STP_RAMP  = 5'h02,
        DICD_STP_QUICK = 5'h04,
        DICD_STP_DC    = 5'h08,
        DICD_STP_COAST = 5'h10
    } dicd_stop_t;
    // command bundle
    typedef struct packed {
        logic       run;
        logic       reverse;
        logic       fwd_only;
        logic       rev_only;
        logic       inch;
        logic       ramp2;
        logic       preset_on;
        logic [1:0] preset_sel;
        logic       frz_ref;
        logic       frz_out;
    } dicd_cmd_t;
endpackage

// ===== dicd_top.sv
// Function
// - per-terminal function code selects its command
// - bandwidth setting 0..100 Hz, zero disables
// - two skip frequencies 0..1000 Hz, banded
// - code 0 terminal fully ignored
// - code 1 rising edge clears alarm
// - code 2 low coasts immediately
// - code 3 low coasts, falling edge resets
// - code 4 low gives quick stop ramp
// - code 5 low DC brakes if settings nonzero
// - code 6 low ramps down on selected ramp
// - code 7 level run command
// - code 8 14 ms pulse latches start
// - code 9 reverses, no start, not closed loop
// - code 10 start plus reverse, latching option
// - codes 11/12 start restricted direction
// - code 13 forces inch unless coasting, quick stopping or DC braking
// - code 14 holds reference, survives stop
// - code 15 holds output frequency
// - fast terminals get constant latency path
// - qualified 14 ms pulses step held value
// - up/down only while frozen, both is down
// - ramp select low first, high second
// - preset enable chooses preset by selects
//
// Our own choices: the address map and register access over Avalon-MM.
module dicd_top #(
    parameter int PULSE_CYCLES = dicd_pkg::PULSE_CYC
) (
    // clock, reset, enable
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rst,
    input  wire logic                    i_ce,
    // terminal pins, bit 0 = terminal 18
    input  wire logic [4:0]              i_term,
    // Avalon-MM slave
    input  wire logic [3:0]              i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [31:0]             i_avs_writedata,
    output logic [31:0]                  o_avs_readdata,
    output logic                         o_avs_waitrequest,
    // drive context
    input  wire logic                    i_closed_loop,
    input  wire logic                    i_dc_time_nz,
    input  wire logic                    i_dc_volt_nz,
    input  wire logic [15:0]             i_live_ref,
    input  wire logic [15:0]             i_live_freq,
    // commands out
    output logic                         o_alarm_clr,
    output logic                         o_coast,
    output dicd_pkg::dicd_stop_t         o_stop,
    output dicd_pkg::dicd_cmd_t          o_cmd,
    output logic [15:0]                  o_hold_val,
    // bypass settings
    output logic [6:0]                   o_bypass_bw,
    output logic [13:0]                  o_skip1,
    output logic [13:0]                  o_skip2,
    output logic                         o_bypass_en
);
    localparam logic [3:0] A_FUNC0 = 4'h0; // five function words 0..4
    localparam logic [3:0] A_BW    = 4'h5;
    localparam logic [3:0] A_SKIP1 = 4'h6;
    localparam logic [3:0] A_SKIP2 = 4'h7;
    localparam logic [3:0] A_STAT  = 4'h8;
    localparam logic [3:0] A_NUM   = 4'h9;
    localparam int CNT_W_L = dicd_pkg::CNT_W;
    localparam logic [CNT_W_L-1:0] PULSE_MAX =
        CNT_W_L'(PULSE_CYCLES - 1);

    // is any terminal mapped to code f and high?
    function automatic logic any_hi(input logic [29:0] fn,
                                    input logic [4:0] lv,
                                    input logic [5:0] f);
        logic r;
        r = 1'b0;
        for (int k = 0; k < 5; k++)
            if (fn[k*6 +: 6] == f && lv[k])
                r = 1'b1;
        return r;
    endfunction
    // is any terminal mapped to code f?
    function automatic logic any_map(input logic [29:0] fn,
                                     input logic [5:0] f);
        logic r;
        r = 1'b0;
        for (int k = 0; k < 5; k++)
            if (fn[k*6 +: 6] == f)
                r = 1'b1;
        return r;
    endfunction

    logic [29:0] func_reg;
    logic [6:0]  bw_reg;
    logic [13:0] skip1_reg;
    logic [13:0] skip2_reg;
    logic [4:0]  s1_reg;
    logic [4:0]  s2_reg;
    logic [4:0]  s3_reg;
    logic [4:0]  lvl_reg;
    logic [4:0]  lvl_prev_reg;
    logic [4:0]  lvl;
    logic [4:0]  lvl_inv;

    // three-stage sync; fast terminals 18/19 take the same fixed path
    // so their latency never varies between activations
    // constant latency
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s1_reg <= 5'h00;
            s2_reg <= 5'h00;
            s3_reg <= 5'h00;
        end else if (i_ce) begin
            s1_reg <= i_term;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // level accepted only where stages two and three agree
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            lvl_reg      <= 5'h00;
            lvl_prev_reg <= 5'h00;
        end else if (i_ce) begin
            lvl_reg      <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
            lvl_prev_reg <= lvl_reg;
        end
    end

    always_comb begin
        for (int k = 0; k < 5; k++) begin
            lvl[k]     = lvl_reg[k] &&
                         (func_reg[k*6 +: 6] != dicd_pkg::FN_NONE);
            lvl_inv[k] = !lvl_reg[k] &&
                         (func_reg[k*6 +: 6] != dicd_pkg::FN_NONE);
        end
    end

    // register bus: one-cycle waitrequest, answers on the second cycle
    logic acc_reg;
    wire  logic req = (i_avs_read || i_avs_write) && !acc_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst)
            acc_reg <= 1'b0;
        else if (i_ce)
            acc_reg <= req;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst)
            func_reg <= dicd_pkg::FUNC_RST;
        else if (i_ce && i_avs_write && acc_reg && i_avs_address < A_BW)
            func_reg[i_avs_address[2:0]*6 +: 6] <= i_avs_writedata[5:0];
    end

    // bandwidth clamps to 100; skip frequencies clamp to 1000.0
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            bw_reg    <= 7'h00;
            skip1_reg <= dicd_pkg::SKIP_RST;
            skip2_reg <= dicd_pkg::SKIP_RST;
        end else if (i_ce && i_avs_write && acc_reg) begin
            if (i_avs_address == A_BW)
                bw_reg <= (i_avs_writedata > 32'(dicd_pkg::BW_MAX_HZ)) ?
                          7'(dicd_pkg::BW_MAX_HZ) : i_avs_writedata[6:0];
            if (i_avs_address == A_SKIP1)
                skip1_reg <= (i_avs_writedata >
                              32'(dicd_pkg::SKIP_MAX_D10)) ?
                             14'(dicd_pkg::SKIP_MAX_D10) :
                             i_avs_writedata[13:0];
            if (i_avs_address == A_SKIP2)
                skip2_reg <= (i_avs_writedata >
                              32'(dicd_pkg::SKIP_MAX_D10)) ?
                             14'(dicd_pkg::SKIP_MAX_D10) :
                             i_avs_writedata[13:0];
        end
    end

    // stop demands from the terminal levels
    wire logic coast_d = any_hi(func_reg, lvl_inv, dicd_pkg::FN_COAST) ||
                         any_hi(func_reg, lvl_inv, dicd_pkg::FN_CLR_CST);
    wire logic dc_d    = any_hi(func_reg, lvl_inv, dicd_pkg::FN_DCHOLD) &&
                         i_dc_time_nz && i_dc_volt_nz;
    wire logic qs_d    = any_hi(func_reg, lvl_inv, dicd_pkg::FN_QSTOP);
    wire logic rs_d    = any_hi(func_reg, lvl_inv, dicd_pkg::FN_STOP);

    // edge based alarm clear
    logic rst_ev;
    always_comb begin
        rst_ev = 1'b0;
        for (int k = 0; k < 5; k++) begin
            if (func_reg[k*6 +: 6] == dicd_pkg::FN_RESET &&
                lvl_reg[k] && !lvl_prev_reg[k])
                rst_ev = 1'b1;
            if (func_reg[k*6 +: 6] == dicd_pkg::FN_CLR_CST &&
                !lvl_reg[k] && lvl_prev_reg[k])
                rst_ev = 1'b1;
        end
    end

    // latched start: pulse must stay high PULSE_CYCLES
    logic [CNT_W_L-1:0] lat_cnt_reg;
    logic               latch_reg;
    wire  logic lat_in = any_hi(func_reg, lvl, dicd_pkg::FN_LATCH);
    wire  logic stopping = coast_d || dc_d || qs_d || rs_d;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            lat_cnt_reg <= '0;
            latch_reg   <= 1'b0;
        end else if (i_ce) begin
            lat_cnt_reg <= lat_in ? ((lat_cnt_reg == PULSE_MAX) ?
                           lat_cnt_reg : lat_cnt_reg + 1'b1) : '0;
            if (stopping)
                latch_reg <= 1'b0;
            else if (lat_in && lat_cnt_reg == PULSE_MAX)
                latch_reg <= 1'b1;
        end
    end

    // speed up / down pulse qualification
    logic [CNT_W_L-1:0] hi_cnt_reg;
    logic [CNT_W_L-1:0] lo_cnt_reg;
    logic               armed_reg;
    logic               dir_dn_reg;
    logic               step_pls;
    wire  logic up_in = any_hi(func_reg, lvl, dicd_pkg::FN_SPD_UP);
    wire  logic dn_in = any_hi(func_reg, lvl, dicd_pkg::FN_SPD_DN);
    wire  logic ud_in = up_in || dn_in;
    // high then low each 14 ms
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hi_cnt_reg <= '0;
            lo_cnt_reg <= '0;
            armed_reg  <= 1'b0;
            dir_dn_reg <= 1'b0;
        end else if (i_ce) begin
            if (ud_in) begin
                lo_cnt_reg <= '0;
                if (hi_cnt_reg != PULSE_MAX)
                    hi_cnt_reg <= hi_cnt_reg + 1'b1;
                else
                    armed_reg <= 1'b1;
                dir_dn_reg <= dn_in;
            end else begin
                hi_cnt_reg <= '0;
                if (lo_cnt_reg != PULSE_MAX)
                    lo_cnt_reg <= lo_cnt_reg + 1'b1;
                else
                    armed_reg <= 1'b0;
            end
        end
    end
    assign step_pls = i_ce && armed_reg && !ud_in &&
                      lo_cnt_reg == PULSE_MAX - 1'b1;

    // freeze: capture live value on entry, then step only
    wire  logic frz_ref = any_hi(func_reg, lvl, dicd_pkg::FN_FRZ_REF);
    wire  logic frz_out = any_hi(func_reg, lvl, dicd_pkg::FN_FRZ_OUT);
    logic       frz_prev_reg;
    logic [15:0] hold_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            hold_reg     <= dicd_pkg::HOLD_RST;
            frz_prev_reg <= 1'b0;
        end else if (i_ce) begin
            frz_prev_reg <= frz_ref || frz_out;
            if ((frz_ref || frz_out) && !frz_prev_reg)
                hold_reg <= frz_ref ? i_live_ref : i_live_freq;
            else if ((frz_ref || frz_out) && step_pls)
                hold_reg <= dir_dn_reg ?
                    ((hold_reg == 16'h0000) ? hold_reg :
                     hold_reg - dicd_pkg::HOLD_STEP) :
                    ((hold_reg == 16'hffff) ? hold_reg :
                     hold_reg + dicd_pkg::HOLD_STEP);
        end
    end

    // run direction decode
    dicd_pkg::dicd_cmd_t cmd_next;
    dicd_pkg::dicd_stop_t stop_next;
    always_comb begin
        logic st_rev;
        logic lat_mode;
        lat_mode = func_reg[5:0] == dicd_pkg::FN_LATCH;
        st_rev   = any_hi(func_reg, lvl, dicd_pkg::FN_STREV) &&
                   !i_closed_loop;
        cmd_next = '0;
        cmd_next.fwd_only = any_hi(func_reg, lvl, dicd_pkg::FN_FWD_EN);
        cmd_next.rev_only = any_hi(func_reg, lvl, dicd_pkg::FN_REV_EN);
        // latched when terminal 18 latches, sole start
        cmd_next.run = any_hi(func_reg, lvl, dicd_pkg::FN_START) ||
                       latch_reg || cmd_next.fwd_only ||
                       cmd_next.rev_only ||
                       (st_rev && !(lat_mode && !latch_reg));
        // reverse only, not in closed loop
        cmd_next.reverse = (any_hi(func_reg, lvl, dicd_pkg::FN_REV) ||
                            st_rev || cmd_next.rev_only) &&
                           !i_closed_loop && !cmd_next.fwd_only;
        cmd_next.inch = any_hi(func_reg, lvl, dicd_pkg::FN_INCH) &&
                        !coast_d && !qs_d && !dc_d;
        cmd_next.ramp2 = any_hi(func_reg, lvl, dicd_pkg::FN_RAMP2);
        cmd_next.preset_on = any_hi(func_reg, lvl, dicd_pkg::FN_PRE_ON);
        cmd_next.preset_sel = {any_hi(func_reg, lvl, dicd_pkg::FN_PRE_MSB),
                               any_hi(func_reg, lvl, dicd_pkg::FN_PRE_LSB)};
        cmd_next.frz_ref = frz_ref;
        cmd_next.frz_out = frz_out;
        if (stopping)
            cmd_next.run = 1'b0;
        if (coast_d)
            stop_next = dicd_pkg::DICD_STP_COAST;
        else if (dc_d)
            stop_next = dicd_pkg::DICD_STP_DC;
        else if (qs_d)
            stop_next = dicd_pkg::DICD_STP_QUICK;
        else if (rs_d)
            stop_next = dicd_pkg::DICD_STP_RAMP;
        else
            stop_next = dicd_pkg::DICD_STP_NONE;
    end

    // registered command outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_cmd       <= '0;
            o_stop      <= dicd_pkg::DICD_STP_NONE;
            o_coast     <= 1'b0;
            o_alarm_clr <= 1'b0;
        end else if (i_ce) begin
            o_cmd       <= cmd_next;
            o_stop      <= stop_next;
            o_coast     <= coast_d; // transistors off at once
            o_alarm_clr <= rst_ev;
        end
    end

    // settings mirrored to outputs; bw of 0 switches bypass off
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_bypass_bw <= 7'h00;
            o_skip1     <= dicd_pkg::SKIP_RST;
            o_skip2     <= dicd_pkg::SKIP_RST;
            o_bypass_en <= 1'b0;
            o_hold_val  <= dicd_pkg::HOLD_RST;
        end else if (i_ce) begin
            o_bypass_bw <= bw_reg;
            o_skip1     <= skip1_reg;
            o_skip2     <= skip2_reg;
            o_bypass_en <= bw_reg != 7'h00;
            o_hold_val  <= hold_reg;
        end
    end

    // read data and waitrequest
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_avs_readdata    <= 32'h0000_0000;
            o_avs_waitrequest <= 1'b1;
        end else if (i_ce) begin
            o_avs_waitrequest <= !req;
            unique case (i_avs_address) inside
                [4'h0:4'h4]: o_avs_readdata <=
                    {26'h0, func_reg[i_avs_address[2:0]*6 +: 6]};
                A_BW:    o_avs_readdata <= {25'h0, bw_reg};
                A_SKIP1: o_avs_readdata <= {18'h0, skip1_reg};
                A_SKIP2: o_avs_readdata <= {18'h0, skip2_reg};
                A_STAT:  o_avs_readdata <= {11'h0, lvl_reg,
                                            hold_reg};
                default: o_avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    coast_first_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && coast_d |=> o_stop == dicd_pkg::DICD_STP_COAST)
        else $error("coast not given priority");
    inch_block_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && qs_d |=> !o_cmd.inch)
        else $error("inch active during quick stop");
    bw_limit_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        bw_reg <= 7'(dicd_pkg::BW_MAX_HZ))
        else $error("bandwidth above limit");
    rev_loop_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && i_closed_loop |=> !o_cmd.reverse)
        else $error("reverse in closed loop");
    latch_time_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(latch_reg) |-> $past(lat_cnt_reg) == PULSE_MAX)
        else $error("latch set early");
    stop_run_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && stopping |=> !o_cmd.run)
        else $error("run during stop");
    dc_gate_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && !i_dc_time_nz && !coast_d |=>
        o_stop != dicd_pkg::DICD_STP_DC)
        else $error("dc brake without settings");
    bw_en_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_ce && bw_reg == 7'h00 |=> !o_bypass_en)
        else $error("bypass enabled at zero bandwidth");
    cov_latch_c: cover property (@(posedge i_clk_sys) $rose(latch_reg));
    cov_step_c:  cover property (@(posedge i_clk_sys) step_pls);
    cov_clr_c:   cover property (@(posedge i_clk_sys) o_alarm_clr);
endmodule

// ===== dicd_term_src.sv
module dicd_term_src (
    // clock
    input  wire logic       i_clk_sys,
    // levels the bench asks for
    input  wire logic [4:0] i_lvl,
    // terminal pins
    output logic      [4:0] o_term
);
    timeunit 1ns;
    timeprecision 1ps;
    // pulse widths
    // a level stands until the bench asks for another, so the bench
    // alone decides how long each pulse and break lasts
    always_ff @(posedge i_clk_sys) begin
        o_term <= i_lvl;
    end
endmodule

// ===== tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PC = 20;
    logic        clk, rst, rd_s, wr_s, dcv, cl, dtn;
    logic [3:0]  adr;
    logic [31:0] wd, q, v;
    logic [4:0]  drv, term;
    logic [15:0] lref;
    logic [31:0] avs_rd;
    logic        waitreq, alarm, coast, en;
    logic [15:0] hold;
    logic [6:0]  bw;
    logic [13:0] s1, s2;
    dicd_pkg::dicd_stop_t stp;
    dicd_pkg::dicd_cmd_t  cmd;
    int n_fail, check_count, seed, n_clr, c, i;

    dicd_term_src src (.i_clk_sys(clk), .i_lvl(drv), .o_term(term));
    dicd_top #(.PULSE_CYCLES(PC)) uut (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_term(term),
        .i_avs_address(adr), .i_avs_read(rd_s), .i_avs_write(wr_s),
        .i_avs_writedata(wd), .o_avs_readdata(avs_rd),
        .o_avs_waitrequest(waitreq), .i_closed_loop(cl),
        .i_dc_time_nz(dtn), .i_dc_volt_nz(dcv), .i_live_ref(lref),
        .i_live_freq(lref), .o_alarm_clr(alarm), .o_coast(coast),
        .o_stop(stp), .o_cmd(cmd), .o_hold_val(hold),
        .o_bypass_bw(bw), .o_skip1(s1), .o_skip2(s2), .o_bypass_en(en));

    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // count alarm clear pulses, they stand one cycle only
    always @(posedge clk) begin
        if (alarm === 1'b1) n_clr++;
    end

    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk_val(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task chk_bit(input logic g, input logic e);
        chk_val({31'h0, g}, {31'h0, e});
    endtask
    // one bus cycle, held until waitrequest is seen low
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        adr  <= a;
        wd   <= d;
        wr_s <= w;
        rd_s <= ~w;
        for (k = 0; k < 40; k++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        q = avs_rd;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
        if (k == 40) begin
            n_fail++;
            test_done();
        end
    endtask
    // move the terminals and let the synchroniser settle
    task set_term(input logic [4:0] t);
        drv <= t;
        repeat (8) @(posedge clk);
    endtask
    // one qualified pulse: level t long enough, then u long enough
    task pulse(input logic [4:0] t, input logic [4:0] u);
        drv <= t;
        repeat (PC + 10) @(posedge clk);
        drv <= u;
        repeat (PC + 10) @(posedge clk);
    endtask
    function automatic logic [31:0] clampf(input logic [31:0] x, m);
        return (x > m) ? m : x;
    endfunction
    function automatic logic [4:0] stop_of(input int f);
        case (f)
            2, 3: return 5'h10;
            4: return 5'h04;
            5: return 5'h08;
            6: return 5'h02;
            default: return 5'h01;
        endcase
    endfunction

    initial begin
        rst = 1'b1;
        rd_s = 1'b0;
        wr_s = 1'b0;
        adr = 4'h0;
        wd = 32'h0;
        dcv = 1'b1;
        cl = 1'b0;
        dtn = 1'b1;
        lref = 16'h0;
        drv = 5'h1f;
        seed = 12;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_val({27'h0, stp}, 32'h1);
        for (i = 0; i < 5; i++) begin
            bus(1'b0, i[3:0], 32'h0);
            chk_val(q, {26'h0, dicd_pkg::FUNC_RST[6*i +: 6]});
        end
        // corners first, then random settings
        for (i = 0; i < 8; i++) begin
            v = (i < 4) ? (i * 33 + 2) : ({$random(seed)} % 200);
            bus(1'b1, 4'h5, (i == 0) ? 32'h0 : v);
            bus(1'b0, 4'h5, 32'h0);
            chk_val(q, clampf((i == 0) ? 32'h0 : v, 100));
            chk_val({25'h0, bw}, q);
            chk_bit(en, q != 0);
            v = (i < 2) ? 32'd10000 + i : ({$random(seed)} % 12000);
            bus(1'b1, 4'h6, v);
            bus(1'b1, 4'h7, v ^ 32'h1);
            // mirrored outputs follow the setting one edge later
            repeat (2) @(posedge clk);
            chk_val({18'h0, s1}, clampf(v, 10000));
            chk_val({18'h0, s2}, clampf(v ^ 32'h1, 10000));
            // top bit clear so one up step never saturates
            lref <= {1'b0, 15'($random(seed))};
        end
        bus(1'b1, 4'h9, 32'hffff_ffff);
        bus(1'b0, 4'h9, 32'h0);
        chk_val(q, 32'h0);
        for (i = 1; i < 5; i++) bus(1'b1, i[3:0], 32'h0);
        // every stop and reset code on terminal 18, low then back high
        for (i = 0; i < 7; i++) begin
            bus(1'b1, 4'h0, i);
            c = n_clr;
            set_term(5'h1e);
            chk_val({27'h0, stp}, {27'h0, stop_of(i)});
            chk_bit(coast, i == 2 || i == 3);
            set_term(5'h1f);
            chk_val(n_clr - c, (i == 1 || i == 3) ? 1 : 0);
        end
        // brake is refused while its voltage or its time setting is zero
        dcv <= 1'b0;
        bus(1'b1, 4'h0, 32'h5);
        set_term(5'h1e);
        chk_val({27'h0, stp}, 32'h1);
        dcv <= 1'b1;
        dtn <= 1'b0;
        repeat (3) @(posedge clk);
        chk_val({27'h0, stp}, 32'h1);
        dtn <= 1'b1;
        set_term(5'h1f);
        bus(1'b1, 4'h0, 32'h7);
        repeat (2) @(posedge clk);
        chk_bit(cmd.run, 1'b1);
        set_term(5'h1e);
        chk_bit(cmd.run, 1'b0);
        // quick stop and coast together, coast wins
        bus(1'b1, 4'h0, 32'h4);
        bus(1'b1, 4'h1, 32'h2);
        set_term(5'h1c);
        chk_val({27'h0, stp}, 32'h10);
        bus(1'b1, 4'h1, 32'h6);
        set_term(5'h1e);
        // latched start from a long enough pulse, cleared by stop
        bus(1'b1, 4'h0, 32'h8);
        drv <= 5'h1f;
        repeat (PC + 10) @(posedge clk);
        set_term(5'h1e);
        chk_bit(cmd.run, 1'b1);
        set_term(5'h1c);
        chk_bit(cmd.run, 1'b0);
        // direction, inch, ramp and preset codes on terminal 18, preset MSB on 19
        for (i = 1; i < 5; i++) bus(1'b1, i[3:0], 32'h0);
        set_term(5'h01);
        bus(1'b1, 4'h0, 32'h9);
        repeat (2) @(posedge clk);
        chk_val({30'h0, cmd.run, cmd.reverse}, 32'h1);
        cl <= 1'b1;
        repeat (3) @(posedge clk);
        chk_bit(cmd.reverse, 1'b0);
        cl <= 1'b0;
        bus(1'b1, 4'h0, 32'hc);
        repeat (2) @(posedge clk);
        chk_val({30'h0, cmd.run, cmd.reverse}, 32'h3);
        bus(1'b1, 4'h0, 32'hb);
        repeat (2) @(posedge clk);
        chk_val({30'h0, cmd.run, cmd.reverse}, 32'h2);
        bus(1'b1, 4'h0, 32'ha);
        repeat (2) @(posedge clk);
        chk_val({30'h0, cmd.run, cmd.reverse}, 32'h3);
        bus(1'b1, 4'h0, 32'hd);
        repeat (2) @(posedge clk);
        chk_bit(cmd.inch, 1'b1);
        bus(1'b1, 4'h0, 32'h15);
        repeat (2) @(posedge clk);
        chk_bit(cmd.ramp2, 1'b1);
        bus(1'b1, 4'h0, 32'h18);
        bus(1'b1, 4'h1, 32'h17);
        set_term(5'h03);
        chk_val({29'h0, cmd.preset_on, cmd.preset_sel}, 32'h6);
        // freeze reference on 27, speed up on 29, speed down on 33
        bus(1'b1, 4'h0, 32'h0);
        bus(1'b1, 4'h1, 32'h0);
        set_term(5'h00);
        bus(1'b1, 4'h2, 32'he);
        bus(1'b1, 4'h3, 32'h10);
        bus(1'b1, 4'h4, 32'h11);
        set_term(5'h04);
        chk_val({16'h0, hold}, {16'h0, lref});
        chk_bit(cmd.frz_ref, 1'b1);
        pulse(5'h0c, 5'h04);
        chk_val({16'h0, hold}, {16'h0, lref + 16'h1});
        pulse(5'h1c, 5'h04);
        chk_val({16'h0, hold}, {16'h0, lref});
        set_term(5'h00);
        pulse(5'h08, 5'h00);
        chk_val({16'h0, hold}, {16'h0, lref});
        test_done();
    end
endmodule
